// ===== pkg/sfp_frame_if.sv
/*
 * carrier between the link receiver and the core: a finished header held
 * stable, and a toggle that flips once per finished header.
 */
`timescale 1ns/1ns
interface sfp_frame_if;
    logic        done_tgl;
    logic [7:0]  opcode;
    logic [23:0] addr;
    modport rx   (output done_tgl, output opcode, output addr);
    modport core (input done_tgl, input opcode, input addr);
endinterface

// ===== pkg/sfp_pkg.sv
/*
 * shared constants, the command format type and the opcode format lookup
 * for the serial flash front end. assumes a 250 mhz core clock.
 */
package sfp_pkg;
    // core clock and power-up delays, in their own units
    localparam int CLK_MHZ        = 250;
    localparam int SEL_DELAY_US   = 50;   // select_after_power_delay, least
    localparam int WRITE_DELAY_MS = 20;   // write_after_power_delay
    localparam int US_PER_MS      = 1000;
    localparam int SEL_DELAY_CYC  = SEL_DELAY_US * CLK_MHZ;
    localparam int WRITE_DELAY_CYC = WRITE_DELAY_MS * US_PER_MS * CLK_MHZ;

    // frame layout
    localparam int OP_BITS   = 8;
    localparam int ADDR_BITS = 24;
    localparam int PAGE_BITS = 11;
    localparam int BYTE_BITS = 9;
    localparam int PAGE_LSB  = 9;
    localparam int PAGE_MSB  = PAGE_LSB + PAGE_BITS - 1;
    localparam int CNT_W     = 7;
    localparam logic [CNT_W-1:0] OP_LAST   = 7'h07;
    localparam logic [CNT_W-1:0] ADDR_LAST = 7'h1f;

    // format fields
    localparam logic [1:0] ADDR_NONE   = 2'h0;
    localparam logic [1:0] ADDR_STD    = 2'h3;
    localparam logic [2:0] DUMMY_NONE  = 3'h0;
    localparam logic [2:0] DUMMY_SHORT = 3'h1;
    localparam logic [2:0] DUMMY_LONG  = 3'h4;
    localparam logic       MODE3_AT_RESET = 1'b1;

    typedef struct packed {
        logic [1:0] addr_bytes;
        logic [2:0] dummy_bytes;
        logic       page_used;
        logic       byte_used;
        logic       known;
        logic       prog;
    } sfp_fmt_t;

    // address/dummy layout of an opcode; unknown ones take three address bytes
    function automatic sfp_fmt_t sfp_format(input logic [7:0] op);
        sfp_fmt_t f;
        f = '{ADDR_STD, DUMMY_NONE, 1'b1, 1'b1, 1'b1, 1'b0};
        case (op)
            8'h03, 8'h0b: f.known = 1'b1;
            8'hd2, 8'he8: f.dummy_bytes = DUMMY_LONG;
            8'hd4, 8'hd6: begin
                f.dummy_bytes = DUMMY_SHORT;
                f.page_used   = 1'b0;
            end
            8'h87, 8'hd1, 8'hd3, 8'h84: f.page_used = 1'b0;
            8'h88, 8'h89, 8'h83, 8'h86, 8'h81, 8'h50, 8'h7c, 8'h58, 8'h59: begin
                f.byte_used = 1'b0;
                f.prog      = 1'b1;
            end
            8'h53, 8'h55, 8'h60, 8'h61: f.byte_used = 1'b0;
            8'h82, 8'h85: f.prog = 1'b1;
            8'h77: begin
                f.page_used = 1'b0;
                f.byte_used = 1'b0;
            end
            8'h9f, 8'hb9, 8'hab, 8'hd7: begin
                f.addr_bytes = ADDR_NONE;
                f.page_used  = 1'b0;
                f.byte_used  = 1'b0;
            end
            default: f.known = 1'b0;
        endcase
        return f;
    endfunction

    // header length in bits, opcode included
    function automatic logic [CNT_W-1:0] sfp_hdr_bits(input sfp_fmt_t f);
        return CNT_W'(OP_BITS) + CNT_W'({f.addr_bytes, 3'h0}) + CNT_W'({f.dummy_bytes, 3'h0});
    endfunction
endpackage

// ===== src/sfp_core.sv
/*
 * serial flash power-up and addressing front end: clock mode detection,
 * power-up delay tracking and decoding of received command headers.
 * assumes clk at 250 mhz and a host that owns sck, cs_n and si.
 */
`timescale 1ns/1ns

module sfp_core
    import sfp_pkg::*;
#(
    parameter int SEL_CYC = sfp_pkg::SEL_DELAY_CYC,
    parameter int WR_CYC  = sfp_pkg::WRITE_DELAY_CYC
)(
    // core clock and reset
    input  wire logic                           clk,
    input  wire logic                           nrst,
    input  wire logic                           ce,
    // link pins
    input  wire logic                           sck,
    input  wire logic                           cs_n,
    input  wire logic                           si,
    output logic                                so,
    output logic                                so_oe_n,
    // decoded command
    output logic                                cmd_valid,
    output logic [sfp_pkg::OP_BITS-1:0]         cmd_opcode,
    output logic [sfp_pkg::PAGE_BITS-1:0]       cmd_page,
    output logic [sfp_pkg::BYTE_BITS-1:0]       cmd_byte,
    output logic                                cmd_known,
    output logic                                cmd_early_write,
    // status
    output logic                                spi_mode3,
    output logic                                sel_ready,
    output logic                                write_ready,
    output logic                                standby
);
    import sfp_pkg::*;

    localparam int TW = $clog2((SEL_CYC > WR_CYC ? SEL_CYC : WR_CYC) + 1);

    sfp_frame_if frame ();

    sfp_link_rx u_rx (
        .sck   (sck),
        .cs_n  (cs_n),
        .si    (si),
        .nrst  (nrst),
        .frame (frame)
    );

    // saturating step shared by both power-up timers
    function automatic logic [TW-1:0] sat_step(input logic [TW-1:0] v, input int lim);
        return (v >= TW'(lim)) ? v : v + TW'(1);
    endfunction

    logic [2:0]    cs_sync;
    logic [2:0]    sck_sync;
    logic [2:0]    tgl_sync;
    logic          cs_lvl;
    logic          sck_lvl;
    logic          tgl_seen;
    logic          cs_fall;
    logic          tgl_evt;
    logic [TW-1:0] sel_cnt;
    logic [TW-1:0] wr_cnt;
    sfp_fmt_t      fmt;

    // pin synchronisers, three stages each; stage 0 feeds only stage 1
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cs_sync  <= 3'h7;
            sck_sync <= 3'h7;
        end else if (ce) begin
            cs_sync  <= {cs_sync[1:0], cs_n};
            sck_sync <= {sck_sync[1:0], sck};
        end
    end

    // toggle synchroniser from the link clock; it is frozen while ce is low, so two headers finished then cancel out
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tgl_sync <= 3'h0;
        end else if (ce) begin
            tgl_sync <= {tgl_sync[1:0], frame.done_tgl};
        end
    end

    // a level only counts once stages one and two agree
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cs_lvl  <= 1'b1;
            sck_lvl <= 1'b1;
        end else if (ce) begin
            if (cs_sync[1] == cs_sync[2]) begin
                cs_lvl <= cs_sync[2];
            end
            if (sck_sync[1] == sck_sync[2]) begin
                sck_lvl <= sck_sync[2];
            end
        end
    end

    assign cs_fall = cs_lvl && (cs_sync[1] == cs_sync[2]) && !cs_sync[2];
    assign tgl_evt = (tgl_sync[1] == tgl_sync[2]) && (tgl_sync[2] != tgl_seen);

    // mode pick: idle clock high at select fall means mode 3, low means mode 0
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            spi_mode3 <= MODE3_AT_RESET;
        end else if (ce && cs_fall) begin
            spi_mode3 <= sck_lvl;
        end
    end

    // standby while deselected; reset counts as deselected
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            standby <= 1'b1;
        end else if (ce) begin
            standby <= cs_lvl;
        end
    end

    // serial output stays undriven: no read data path sits in this block
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            so      <= 1'b0;
            so_oe_n <= 1'b1;
        end else if (ce) begin
            so      <= 1'b0;
            so_oe_n <= 1'b1;
        end
    end

    // select timer runs from reset release; the host keeps to it
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sel_cnt   <= '0;
            sel_ready <= 1'b0;
        end else if (ce) begin
            sel_cnt   <= sat_step(sel_cnt, SEL_CYC);
            sel_ready <= (sel_cnt >= TW'(SEL_CYC));
        end
    end

    // write timer; shares the counter width so one step function serves both
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wr_cnt      <= '0;
            write_ready <= 1'b0;
        end else if (ce) begin
            wr_cnt      <= sat_step(wr_cnt, WR_CYC);
            write_ready <= (wr_cnt >= TW'(WR_CYC));
        end
    end

    assign fmt = sfp_format(frame.opcode);

    // last toggle level taken; reset forgets any header seen before it
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tgl_seen <= 1'b0;
        end else if (ce && tgl_evt) begin
            tgl_seen <= tgl_sync[2];
        end
    end

    // one-cycle pulse per finished header
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cmd_valid <= 1'b0;
        end else if (ce) begin
            cmd_valid <= tgl_evt;
        end
    end

    // decoded fields; the held words are stable long before the toggle lands
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cmd_opcode <= '0;
            cmd_page   <= '0;
            cmd_byte   <= '0;
            cmd_known  <= 1'b0;
        end else if (ce && tgl_evt) begin
            cmd_opcode <= frame.opcode;
            // page field from the upper address bits
            cmd_page   <= fmt.page_used ? frame.addr[PAGE_MSB:PAGE_LSB] : '0;
            // buffer-only opcodes keep just the byte field
            cmd_byte   <= fmt.byte_used ? frame.addr[BYTE_BITS-1:0] : '0;
            cmd_known  <= fmt.known;
        end
    end

    // an early program or erase is only flagged: refusing it here would
    // hide the host's timing mistake from whatever sits behind this block
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cmd_early_write <= 1'b0;
        end else if (ce && tgl_evt) begin
            cmd_early_write <= fmt.prog && !write_ready;
        end
    end
endmodule

// ===== src/sfp_link_rx.sv
/*
 * link-side header receiver, clocked by the host's serial clock.
 * assumes si is sampled on the rising clock edge in both modes 0 and 3.
 */
`timescale 1ns/1ns
module sfp_link_rx
    import sfp_pkg::*;
(
    // link pins
    input  wire logic   sck,
    input  wire logic   cs_n,
    input  wire logic   si,
    // reset
    input  wire logic   nrst,
    // header to the core
    sfp_frame_if.rx     frame
);
    import sfp_pkg::*;

    logic [CNT_W-1:0] cnt;
    logic [7:0]       op_sh;
    logic [23:0]      addr_sh;
    logic             done;
    logic             frame_rst_n;
    logic [7:0]       next_op;
    logic [23:0]      next_addr;
    logic             fin;

    // select high clears the frame, so a header cut short is dropped
    assign frame_rst_n = nrst & ~cs_n;

    always_comb begin
        next_op   = (cnt <= OP_LAST) ? {op_sh[6:0], si} : op_sh;
        next_addr = (cnt > OP_LAST && cnt <= ADDR_LAST) ? {addr_sh[22:0], si} : addr_sh;
        // header ends after opcode, address and dummy bytes
        fin = !done && (cnt + 7'h01 == sfp_hdr_bits(sfp_format(next_op)));
    end

    // bit shifting; the clock may stop between frames, nothing waits on it
    always_ff @(posedge sck or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            cnt     <= '0;
            op_sh   <= '0;
            addr_sh <= '0;
            done    <= 1'b0;
        end else if (!done) begin
            cnt     <= cnt + 7'h01;
            op_sh   <= next_op;
            addr_sh <= next_addr;
            done    <= fin;
        end
    end

    // held words survive select going high, only nrst clears them
    always_ff @(posedge sck or negedge nrst) begin
        if (!nrst) begin
            frame.done_tgl <= 1'b0;
            frame.opcode   <= '0;
            frame.addr     <= '0;
        end else if (fin) begin
            frame.done_tgl <= ~frame.done_tgl;
            frame.opcode   <= next_op;
            frame.addr     <= next_addr;
        end
    end
endmodule

// ===== verification/sfp_core_assertions.sv
/* checker for the flash front end, watching only the core's ports.
   assumes its timer parameters match those of the bound instance. */
`timescale 1ns/1ns
module sfp_core_assertions
#(
    parameter int SEL_CYC = 20,
    parameter int WR_CYC  = 40
)(
    // clock and reset
    input wire logic        clk,
    input wire logic        nrst,
    input wire logic        ce,
    // watched outputs
    input wire logic        so,
    input wire logic        so_oe_n,
    input wire logic        cmd_valid,
    input wire logic [7:0]  cmd_opcode,
    input wire logic [10:0] cmd_page,
    input wire logic [8:0]  cmd_byte,
    input wire logic        spi_mode3,
    input wire logic        sel_ready,
    input wire logic        write_ready,
    input wire logic        standby
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // cycles since release, saturating so it never wraps on long runs
    int cnt;
    always_ff @(posedge clk or negedge nrst)
        if (!nrst) cnt <= 0;
        else if (ce && cnt < WR_CYC + 8) cnt <= cnt + 1;

    a_out_undriven: assert property (so_oe_n && !so)
        else $error("serial output driven");
    a_reset_state: assert property ($rose(nrst) |-> spi_mode3 && standby && !cmd_valid)
        else $error("state after reset wrong");
    a_mode_selected: assert property ($changed(spi_mode3) |=> !standby)
        else $error("mode changed while deselected");
    a_valid_pulse: assert property (cmd_valid |=> !cmd_valid)
        else $error("header pulse too long");
    a_fields_hold: assert property (!cmd_valid |-> $stable({cmd_opcode, cmd_page, cmd_byte}))
        else $error("decoded fields moved");
    a_buffer_no_page: assert property (cmd_valid && cmd_opcode inside
        {8'h87, 8'hd1, 8'hd3, 8'hd4, 8'hd6} |-> cmd_page == 11'h000)
        else $error("buffer opcode kept page");
    a_page_no_byte: assert property (cmd_valid && cmd_opcode inside {8'h88, 8'h89}
        |-> cmd_byte == 9'h000)
        else $error("page opcode kept byte");
    a_no_addr_zero: assert property (cmd_valid && cmd_opcode inside
        {8'h9f, 8'hb9, 8'hab, 8'hd7} |-> {cmd_page, cmd_byte} == 20'h00000)
        else $error("short opcode got an address");
    a_sel_early: assert property (cnt < SEL_CYC |-> !sel_ready)
        else $error("select ready too soon");
    a_sel_late: assert property (cnt > SEL_CYC + 3 |-> sel_ready)
        else $error("select ready too late");
    a_write_late: assert property (cnt > WR_CYC + 3 |-> write_ready && sel_ready)
        else $error("write ready too late");
endmodule

bind sfp_core sfp_core_assertions #(.SEL_CYC(SEL_CYC), .WR_CYC(WR_CYC)) chk (
    .clk(clk), .nrst(nrst), .ce(ce), .so(so), .so_oe_n(so_oe_n), .cmd_valid(cmd_valid),
    .cmd_opcode(cmd_opcode), .cmd_page(cmd_page), .cmd_byte(cmd_byte),
    .spi_mode3(spi_mode3), .sel_ready(sel_ready), .write_ready(write_ready),
    .standby(standby)
);

// ===== verification/sfp_host_model.sv
/* host controller model: owns select, serial clock and serial data.
   assumes the bench calls frame() and waits the power-up delays itself. */
`timescale 1ns/1ns
module sfp_host_model (
    // link pins
    output logic sck,
    output logic cs_n,
    output logic si
);
    initial begin
        sck = 1'b1;
        cs_n = 1'b1;
        si = 1'b0;
    end
    // one frame, msb first, clock stopped outside it; n below the header length cuts it
    task automatic frame(input logic [63:0] bits, input int n, input logic m3);
        #3 sck = m3;
        #20 cs_n = 1'b0;
        #6;
        for (int i = 63; i > 63 - n; i--) begin
            sck = 1'b0;
            si = bits[i];
            #6 sck = 1'b1;
            #6;
        end
        sck = m3;
        #6 cs_n = 1'b1;
        si = ~si; // released data line must not look like a held value
        #60;
    endtask
endmodule

// ===== verification/testbench.sv
/* self-checking bench for the flash front end with a host model on the link.
   assumes the checker binds itself to the core. */
`timescale 1ns/1ns
module testbench;
    localparam int SEL = 20;
    localparam int WR  = 300;
    localparam logic [23:0] A = 24'hf5a5a5; // spare nibble set on purpose
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic ce = 1'b1;
    logic sck, cs_n, si, so, so_oe_n, cmd_valid, cmd_known, cmd_early_write;
    logic spi_mode3, sel_ready, write_ready, standby;
    logic [7:0]  cmd_opcode;
    logic [10:0] cmd_page;
    logic [8:0]  cmd_byte;
    int errors = 0;
    int tests_run = 0;
    int pulses = 0;
    always #2 clk = ~clk;
    sfp_core #(.SEL_CYC(SEL), .WR_CYC(WR)) DUT (.clk(clk), .nrst(nrst), .ce(ce),
        .sck(sck), .cs_n(cs_n), .si(si), .so(so), .so_oe_n(so_oe_n),
        .cmd_valid(cmd_valid), .cmd_opcode(cmd_opcode), .cmd_page(cmd_page),
        .cmd_byte(cmd_byte), .cmd_known(cmd_known), .cmd_early_write(cmd_early_write),
        .spi_mode3(spi_mode3), .sel_ready(sel_ready), .write_ready(write_ready),
        .standby(standby));
    sfp_host_model host (.sck(sck), .cs_n(cs_n), .si(si));
    // count finished headers
    always @(posedge clk) if (cmd_valid === 1'b1) pulses++;

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic results;
        $display("mismatches %0d of %0d checks", errors, tests_run);
        if (errors == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // bounded wait for a power-up timer; running out ends the run
    task automatic wait_rdy(input logic wr);
        for (int i = 0; i < WR + 50; i++)
            if ((wr ? write_ready : sel_ready) !== 1'b1) @(posedge clk);
        if ((wr ? write_ready : sel_ready) !== 1'b1) begin
            errors++;
            results;
        end
    endtask
    // one header through the host, then compare the decode
    task automatic cmd(input logic [7:0] op, input int n, input logic m3,
                       input logic pg, input logic by, input logic early);
        int p0;
        p0 = pulses;
        host.frame({op, A, 32'hffffffff}, n, m3);
        repeat (8) @(posedge clk);
        check(pulses - p0, 1);
        check(cmd_opcode, op);
        check(cmd_page, pg ? A[19:9] : 11'h000);
        check(cmd_byte, by ? A[8:0] : 9'h000);
        check(cmd_early_write, early);
        check(spi_mode3, m3);
        check(cmd_known, 1'b1);
    endtask
    task automatic t_powerup;
        check(spi_mode3, 1'b1);
        check({so_oe_n, so}, 2'b10);
        check(standby, 1'b1);
        check(sel_ready, 1'b0);
    endtask
    task automatic t_early;
        wait_rdy(1'b0);
        cmd(8'h88, 32, 1'b0, 1'b1, 1'b0, 1'b1);
    endtask
    task automatic t_stream;
        wait_rdy(1'b1);
        cmd(8'hd2, 64, 1'b1, 1'b1, 1'b1, 1'b0);
        cmd(8'h03, 32, 1'b0, 1'b1, 1'b1, 1'b0);
        cmd(8'he8, 64, 1'b1, 1'b1, 1'b1, 1'b0);
        cmd(8'h89, 32, 1'b1, 1'b1, 1'b0, 1'b0);
    endtask
    task automatic t_buffer;
        logic [7:0] ops [5] = '{8'h87, 8'hd1, 8'hd3, 8'hd4, 8'hd6};
        for (int i = 0; i < 5; i++)
            cmd(ops[i], i > 2 ? 40 : 32, i[0], 1'b0, 1'b1, 1'b0);
    endtask
    task automatic t_noaddr;
        logic [7:0] ops [4] = '{8'h9f, 8'hb9, 8'hab, 8'hd7};
        for (int i = 0; i < 4; i++)
            cmd(ops[i], 8, i[0], 1'b0, 1'b0, 1'b0);
    endtask
    // a header cut short is dropped, the next one still lands
    task automatic t_cut;
        int p0;
        p0 = pulses;
        host.frame({8'h03, A, 32'h0}, 20, 1'b1);
        repeat (20) @(posedge clk);
        check(pulses - p0, 0);
        cmd(8'h0b, 32, 1'b1, 1'b1, 1'b1, 1'b0);
        // an opcode outside the table still takes three address bytes
        p0 = pulses;
        host.frame({8'h00, A, 32'h0}, 32, 1'b0);
        repeat (8) @(posedge clk);
        check(pulses - p0, 1);
        check(cmd_opcode, 8'h00);
        check(cmd_known, 1'b0);
        check(cmd_page, A[19:9]);
    endtask
    // traffic under reset is ignored and the timers start over
    task automatic t_reset;
        int p0;
        p0 = pulses;
        @(posedge clk) nrst <= 1'b0;
        host.frame({8'h03, A, 32'h0}, 32, 1'b0);
        @(posedge clk) nrst <= 1'b1;
        repeat (8) @(posedge clk);
        check(pulses - p0, 0);
        check(spi_mode3, 1'b1);
        check(sel_ready, 1'b0);
        // clock enable low freezes the select timer
        ce <= 1'b0;
        repeat (SEL + 8) @(posedge clk);
        check(sel_ready, 1'b0);
        ce <= 1'b1;
        wait_rdy(1'b0);
    endtask
    initial begin
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        repeat (2) @(posedge clk);
        t_powerup;
        t_early;
        t_stream;
        t_buffer;
        t_noaddr;
        t_cut;
        t_reset;
        results;
    end
endmodule
